// [verilog/esid_decode.sv]
// Purpose: Stack extension instruction decode and execute
// Assumes: One opcode per cycle on instr_i; memory writes take one cycle
// Notes:   Ordinary instruction operands are remapped here, executed elsewhere
// What this block does
// - Push literal stores immediate at frame pointer
// - Push then decrements frame pointer by one
// - Subtract six-bit immediate from chosen pointer
// - Two-bit selector picks pointer zero to two
// - Selector three subtracts frame, returns, two cycles
// - Extension enable also turns on offset addressing
// - Disabled: access bank or bank register addressing
// - Enabled, access clear, low argument: frame-relative
// - Arguments above 5Fh keep literal addressing
// - Remap applies to all access-bit instructions
// - Frame pointer zero gives access bank address
// - Destination select bit keeps its meaning
// - Configuration bit, default clear, gates extension
// - Indexed move uses frame plus seven-bit offsets
`timescale 1ns/100ps
`include "esid_defines.svh"
module esid_decode (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        extension_enable_cfg_bit_i,
  input  wire logic        instr_valid_i,
  input  wire logic [15:0] instr_i,
  input  wire logic        has_access_bit_i,
  input  wire logic [3:0]  bank_select_reg_i,
  input  wire logic [20:0] return_stack_top_i,
  input  wire logic [7:0]  mem_rdata_i,
  output logic             busy_o,
  output logic [11:0]      operand_addr_o,
  output logic             operand_to_wreg_o,
  output logic             mem_we_o,
  output logic [11:0]      mem_addr_o,
  output logic [7:0]       mem_wdata_o,
  output logic             pc_load_o,
  output logic [20:0]      pc_value_o,
  output logic [11:0]      file_select_pointer0_o,
  output logic [11:0]      file_select_pointer1_o,
  output logic [11:0]      stack_frame_pointer_o
);
  import esid_pkg::*;

  // ==========================================
  // Decode
  // ==========================================
  logic         ext_on;
  logic         is_push;
  logic         is_subp;
  logic         is_movs;
  logic [1:0]   sel;
  logic [5:0]   k6;
  logic [7:0]   farg;
  logic [11:0]  ptr_reg [0:2];
  logic [11:0]  ptr_next [0:2];
  esid_state_t  state_reg;
  esid_state_t  state_next;
  logic         late_reg;
  logic         late_next;
  logic [11:0]  frame_ofs_addr;
  logic         remap_take;
  logic         ret_take;
  logic [7:0]   data_reg;
  logic [7:0]   data_next;
  logic         we_next;
  logic [11:0]  addr_next;
  logic [7:0]   wdata_next;
  logic         pcl_next;
  logic [20:0]  pcv_next;
  logic         we_reg;
  logic [11:0]  addr_reg;
  logic [7:0]   wdata_reg;
  logic         pcl_reg;
  logic [20:0]  pcv_reg;
  logic [11:0]  opaddr_reg;
  logic [11:0]  opaddr_next;
  logic         towreg_reg;
  logic         towreg_next;

  // Extended opcodes decode only when the configuration bit is set
  assign ext_on  = extension_enable_cfg_bit_i;
  assign is_push = ext_on && instr_i[15:8] == `ESID_PUSH_OPC;
  assign is_subp = ext_on && instr_i[15:8] == `ESID_SUBP_OPC;
  assign is_movs = ext_on && instr_i[15:8] == `ESID_MOVS_OPC && instr_i[7];
  assign sel     = instr_i[7:6];
  assign k6      = instr_i[5:0];
  assign farg    = instr_i[7:0];
  assign frame_ofs_addr = 12'(ptr_reg[2] + {5'h00, instr_i[6:0]});
  assign remap_take     = instr_valid_i && state_reg == ESID_EXEC && has_access_bit_i;
  assign ret_take       = instr_valid_i && state_reg == ESID_EXEC && is_subp && sel == `ESID_SEL_RET;

  // ==========================================
  // Next state
  // ==========================================
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      ptr_next[i] = ptr_reg[i];
    end
    state_next   = state_reg;
    late_next    = late_reg;
    data_next    = data_reg;
    we_next      = 1'b0;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    case (state_reg)
      ESID_EXEC:
      begin
        if (instr_valid_i)
        begin
          if (is_push)
          begin
            // Store uses the old pointer, registered on the same edge that the decrement lands
            we_next     = 1'b1;
            addr_next   = ptr_reg[2];
            wdata_next  = instr_i[7:0];
            ptr_next[2] = ptr_reg[2] - 12'h001;
          end
          else if (is_subp)
          begin
            if (sel == `ESID_SEL_RET)
            begin
              ptr_next[2] = ptr_reg[2] - {6'h00, k6};
              state_next  = ESID_RET_IDLE;
            end
            else
            begin
              // No status flags are touched here
              ptr_next[sel] = ptr_reg[sel] - {6'h00, k6};
            end
          end
          else if (is_movs)
          begin
            // A write still in flight owns the port; then the source is read next cycle
            addr_next  = frame_ofs_addr;
            late_next  = we_reg;
            data_next  = mem_rdata_i;
            state_next = ESID_MOV_DEST;
          end
        end
      end
      ESID_RET_IDLE:
      begin
        state_next = ESID_EXEC;
      end
      ESID_MOV_DEST:
      begin
        // Upper bits of the second word are not checked
        if (instr_valid_i)
        begin
          we_next    = 1'b1;
          addr_next  = frame_ofs_addr;
          wdata_next = late_reg ? mem_rdata_i : data_reg;
          state_next = ESID_EXEC;
        end
      end
      default:
      begin
        state_next = ESID_EXEC;
      end
    endcase
  end

  // ==========================================
  // Operand remap
  // ==========================================
  always_comb
  begin
    opaddr_next = opaddr_reg;
    towreg_next = towreg_reg;
    if (remap_take)
    begin
      towreg_next = ~instr_i[9];
      if (ext_on && !instr_i[8] && farg <= `ESID_OFS_LIMIT)
      begin
        // Frame zero maps back onto the low access bank
        opaddr_next = 12'(ptr_reg[2] + {4'h0, farg});
      end
      else if (instr_i[8])
      begin
        opaddr_next = {bank_select_reg_i, farg};
      end
      else if (farg < `ESID_ACCESS_SPLIT)
      begin
        opaddr_next = {4'h0, farg};
      end
      else
      begin
        opaddr_next = {`ESID_HIGH_BANK, farg};
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      opaddr_reg <= 12'h000;
      towreg_reg <= 1'b0;
    end
    else
    begin
      opaddr_reg <= opaddr_next;
      towreg_reg <= towreg_next;
    end
  end

  // ==========================================
  // Return load
  // ==========================================
  // One-cycle pulse; the idle cycle after it swallows the next word
  always_comb
  begin
    pcl_next = 1'b0;
    pcv_next = pcv_reg;
    if (ret_take)
    begin
      pcl_next = 1'b1;
      pcv_next = return_stack_top_i;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      pcl_reg <= 1'b0;
      pcv_reg <= 21'h000000;
    end
    else
    begin
      pcl_reg <= pcl_next;
      pcv_reg <= pcv_next;
    end
  end

  // ==========================================
  // Pointers
  // ==========================================
  // One register per pointer, all with the same reset value
  for (genvar g = 0; g < 3; g++)
  begin : g_ptr
    always_ff @(posedge sys_clk_i)
    begin
      if (!reset_n_i)
      begin
        ptr_reg[g] <= `ESID_PTR_RST;
      end
      else
      begin
        ptr_reg[g] <= ptr_next[g];
      end
    end
  end

  // ==========================================
  // Registers
  // ==========================================
  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= ESID_EXEC;
      late_reg  <= 1'b0;
      data_reg  <= 8'h00;
      we_reg    <= 1'b0;
      addr_reg  <= 12'h000;
      wdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      late_reg  <= late_next;
      data_reg  <= data_next;
      we_reg    <= we_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
    end
  end

  // ==========================================
  // Outputs
  // ==========================================
  // Source read is combinational, but never while a write holds the port
  assign mem_addr_o = (state_reg == ESID_EXEC && is_movs && !we_reg)
                      ? frame_ofs_addr : addr_reg;
  assign busy_o                 = state_reg != ESID_EXEC;
  assign operand_addr_o         = opaddr_reg;
  assign operand_to_wreg_o      = towreg_reg;
  assign mem_we_o               = we_reg;
  assign mem_wdata_o            = wdata_reg;
  assign pc_load_o              = pcl_reg;
  assign pc_value_o             = pcv_reg;
  assign file_select_pointer0_o = ptr_reg[0];
  assign file_select_pointer1_o = ptr_reg[1];
  assign stack_frame_pointer_o  = ptr_reg[2];
endmodule

// [pkg/esid_defines.svh]
// Purpose: Constants for the stack extension decode block
// Assumes: 12-bit data address, 16-bit opcodes
// Notes:   Definitions only
`ifndef ESID_DEFINES_SVH
`define ESID_DEFINES_SVH
`define ESID_PUSH_OPC     8'hFA
`define ESID_SUBP_OPC     8'hE9
`define ESID_MOVS_OPC     8'hEB
`define ESID_SEL_RET      2'h3
`define ESID_SEL_FRAME    2'h2
`define ESID_OFS_LIMIT    8'h5F
`define ESID_ACCESS_SPLIT 8'h60
`define ESID_HIGH_BANK    4'hF
`define ESID_PTR_RST      12'h000
`endif

// [pkg/esid_pkg.sv]
// Purpose: Types for the stack extension decode block
// Assumes: Used with esid_defines.svh
// Notes:   Types only
package esid_pkg;
  typedef enum logic [2:0] {
    ESID_EXEC     = 3'b001,
    ESID_RET_IDLE = 3'b010,
    ESID_MOV_DEST = 3'b100
  } esid_state_t;
endpackage

// [bench/esid_decode_properties.sv]
// Purpose: Port assertions for esid_decode
// Assumes: Config bit held static while opcodes flow
// Notes:   Bound after endmodule
`timescale 1ns/100ps
`include "esid_defines.svh"
module esid_decode_chk (
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        extension_enable_cfg_bit_i,
  input wire logic        instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic        has_access_bit_i,
  input wire logic [3:0]  bank_select_reg_i,
  input wire logic [20:0] return_stack_top_i,
  input wire logic        busy_o,
  input wire logic [11:0] operand_addr_o,
  input wire logic        operand_to_wreg_o,
  input wire logic        mem_we_o,
  input wire logic [11:0] mem_addr_o,
  input wire logic [7:0]  mem_wdata_o,
  input wire logic        pc_load_o,
  input wire logic [20:0] pc_value_o,
  input wire logic [11:0] file_select_pointer0_o,
  input wire logic [11:0] file_select_pointer1_o,
  input wire logic [11:0] stack_frame_pointer_o
);
  // ==========
  // Properties
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  wire        tk  = instr_valid_i && !busy_o;
  wire        ex  = tk && extension_enable_cfg_bit_i;
  wire        sa  = tk && has_access_bit_i;
  wire [11:0] f12 = {4'h0, instr_i[7:0]};
  wire [11:0] k12 = {6'h00, instr_i[5:0]};
  wire [11:0] bka = {bank_select_reg_i, instr_i[7:0]};
  // Upper access half sits at the top of the map
  wire [11:0] lta = {(instr_i[7:0] > 8'h5F) ? 4'hF : 4'h0, instr_i[7:0]};
  property p_push;
    ex && instr_i[15:8] == `ESID_PUSH_OPC |=> mem_we_o && mem_wdata_o == $past(instr_i[7:0])
      && mem_addr_o == $past(stack_frame_pointer_o)
      && stack_frame_pointer_o == $past(stack_frame_pointer_o) - 12'h001;
  endproperty
  a_push: assert property (p_push) else $error("push store wrong");
  property p_ret;
    ex && instr_i[15:6] == {`ESID_SUBP_OPC, 2'h3} |=> pc_load_o && busy_o
      && pc_value_o == $past(return_stack_top_i) ##1 !busy_o && !pc_load_o;
  endproperty
  a_ret: assert property (p_ret) else $error("return wrong");
  property p_sub;
    ex && instr_i[15:6] == {`ESID_SUBP_OPC, 2'h0}
      |=> file_select_pointer0_o == $past(file_select_pointer0_o) - $past(k12);
  endproperty
  a_sub: assert property (p_sub) else $error("pointer subtract wrong");
  property p_sub1;
    ex && instr_i[15:6] == {`ESID_SUBP_OPC, 2'h1}
      |=> file_select_pointer1_o == $past(file_select_pointer1_o) - $past(k12);
  endproperty
  a_sub1: assert property (p_sub1) else $error("pointer one subtract wrong");
  property p_sub2;
    ex && instr_i[15:6] == {`ESID_SUBP_OPC, 2'h2}
      |=> stack_frame_pointer_o == $past(stack_frame_pointer_o) - $past(k12);
  endproperty
  a_sub2: assert property (p_sub2) else $error("frame subtract wrong");
  property p_mov;
    busy_o && !pc_load_o && instr_valid_i
      |=> mem_we_o && mem_addr_o == $past(stack_frame_pointer_o) + {5'h00, $past(instr_i[6:0])};
  endproperty
  a_mov: assert property (p_mov) else $error("indexed move write wrong");
  property p_off;
    sa && extension_enable_cfg_bit_i && !instr_i[8] && instr_i[7:0] <= 8'h5F
      |=> operand_addr_o == $past(stack_frame_pointer_o) + $past(f12);
  endproperty
  a_off: assert property (p_off) else $error("offset address wrong");
  property p_lit;
    sa && !instr_i[8] && (!extension_enable_cfg_bit_i || instr_i[7:0] > 8'h5F) |=> operand_addr_o == $past(lta);
  endproperty
  a_lit: assert property (p_lit) else $error("access address wrong");
  property p_bnk;
    sa && instr_i[8] |=> operand_addr_o == $past(bka);
  endproperty
  a_bnk: assert property (p_bnk) else $error("banked address wrong");
  property p_dst;
    sa |=> operand_to_wreg_o == !$past(instr_i[9]);
  endproperty
  a_dst: assert property (p_dst) else $error("destination wrong");
  property p_off_cfg;
    !extension_enable_cfg_bit_i |=> !mem_we_o && !pc_load_o;
  endproperty
  a_off_cfg: assert property (p_off_cfg) else $error("extension not gated");
  c_push: cover property (ex && instr_i[15:8] == `ESID_PUSH_OPC);
  c_move: cover property (busy_o ##1 mem_we_o);
  c_zero: cover property (sa && stack_frame_pointer_o == 12'h000);
endmodule
bind esid_decode esid_decode_chk i_esid_decode_chk (
  .sys_clk_i                  (sys_clk_i),
  .reset_n_i                  (reset_n_i),
  .extension_enable_cfg_bit_i (extension_enable_cfg_bit_i),
  .instr_valid_i              (instr_valid_i),
  .instr_i                    (instr_i),
  .has_access_bit_i           (has_access_bit_i),
  .bank_select_reg_i          (bank_select_reg_i),
  .return_stack_top_i         (return_stack_top_i),
  .busy_o                     (busy_o),
  .operand_addr_o             (operand_addr_o),
  .operand_to_wreg_o          (operand_to_wreg_o),
  .mem_we_o                   (mem_we_o),
  .mem_addr_o                 (mem_addr_o),
  .mem_wdata_o                (mem_wdata_o),
  .pc_load_o                  (pc_load_o),
  .pc_value_o                 (pc_value_o),
  .file_select_pointer0_o     (file_select_pointer0_o),
  .file_select_pointer1_o     (file_select_pointer1_o),
  .stack_frame_pointer_o      (stack_frame_pointer_o)
);

// [bench/tb.sv]
// Purpose: Self-checking bench for esid_decode
// Assumes: Writes and loads arrive one edge after issue
// Notes:   Operand addressing judged by the checker
`timescale 1ns/100ps
`include "esid_defines.svh"
module tb;
  // ==========
  // Stimulus and model
  logic        clk = 0, rst_n = 0, cfg = 1, vld = 0, acc = 0, busy, to_w, we, pcl;
  logic [15:0] ins = 0;
  logic [3:0]  bank_select_reg = 0;
  logic [20:0] return_stack_top = 0, pcv;
  logic [7:0]  rd, wd, mem_m [0:4095];
  logic [11:0] oa, ma, p0, p1, sfp, m_sfp = 0, m_p0 = 0, m_p1 = 0;
  logic [31:0] qw[$], qp[$];
  int          num_errors = 0, checks = 0;
  initial forever #2.5 clk = ~clk;
  // Data memory answers combinationally, as the block expects
  assign rd = mem_m[ma];
  esid_decode i_esid_decode (.sys_clk_i(clk), .reset_n_i(rst_n), .extension_enable_cfg_bit_i(cfg),
    .instr_valid_i(vld), .instr_i(ins), .has_access_bit_i(acc), .bank_select_reg_i(bank_select_reg),
    .return_stack_top_i(return_stack_top), .mem_rdata_i(rd), .busy_o(busy), .operand_addr_o(oa),
    .operand_to_wreg_o(to_w), .mem_we_o(we), .mem_addr_o(ma), .mem_wdata_o(wd), .pc_load_o(pcl),
    .pc_value_o(pcv), .file_select_pointer0_o(p0), .file_select_pointer1_o(p1), .stack_frame_pointer_o(sfp));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (e !== g)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic op(input logic [15:0] w, input logic a);
    @(negedge clk);
    vld = 1;
    ins = w;
    acc = a;
    bank_select_reg = 4'($urandom);
  endtask
  task automatic stdops(input int n);
    repeat (n) op({4'h2, 12'($urandom)}, 1);
  endtask
  task automatic push(input logic [7:0] k);
    op({`ESID_PUSH_OPC, k}, 0);
    qw.push_back({m_sfp, k});
    m_sfp--;
  endtask
  task automatic idle(input int n);
    @(negedge clk);
    vld = 0;
    repeat (n) @(negedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Results are matched oldest first
  always @(posedge clk)
  begin
    if (we === 1'b1)
      mem_m[ma] <= wd;
    #1;
    if (we === 1'b1)
      cmp("write", qw.size() ? qw.pop_front() : 'x, {ma, wd});
    if (pcl === 1'b1)
      cmp("pc", qp.size() ? qp.pop_front() : 'x, pcv);
  end
  initial
  begin
    logic [5:0] k;
    logic [7:0] v;
    k = 6'($urandom(18));
    repeat (6) @(negedge clk);
    rst_n = 1;
    stdops(12);
    repeat (4) push(8'($urandom));
    stdops(12);
    $display("push and operand test done");
    for (int s = 0; s < 3; s++)
    begin
      k = 6'($urandom);
      op({`ESID_SUBP_OPC, 2'(s), k}, 0);
      if (s == 0) m_p0 -= {6'h00, k};
      if (s == 1) m_p1 -= {6'h00, k};
      if (s == 2) m_sfp -= {6'h00, k};
    end
    return_stack_top = 21'($urandom);
    k = 6'($urandom);
    op({`ESID_SUBP_OPC, 2'h3, k}, 0);
    qp.push_back({11'h000, return_stack_top});
    m_sfp -= {6'h00, k};
    // Ignored: lands in the idle cycle
    op({`ESID_PUSH_OPC, 8'h5A}, 0);
    push(8'($urandom));
    idle(1);
    cmp("ptr0", m_p0, p0);
    cmp("ptr1", m_p1, p1);
    cmp("sfp", m_sfp, sfp);
    $display("subtract test done");
    v = 8'($urandom);
    k = 6'($urandom);
    // Source is the byte just pushed, while that write still holds the port
    push(v);
    op({`ESID_MOVS_OPC, 1'b1, 7'h01}, 0);
    op({9'h1E0, 7'(k) + 7'h02}, 0);
    qw.push_back({m_sfp + 12'(k) + 12'h002, v});
    idle(1);
    op({`ESID_MOVS_OPC, 1'b1, 7'(k) + 7'h02}, 0);
    op({9'h1E0, 7'(k) + 7'h03}, 0);
    qw.push_back({m_sfp + 12'(k) + 12'h003, v});
    idle(2);
    $display("move test done");
    cfg = 0;
    op({`ESID_PUSH_OPC, 8'h11}, 0);
    op({`ESID_SUBP_OPC, 2'h3, 6'h01}, 0);
    stdops(12);
    idle(3);
    cmp("left", 0, qw.size() + qp.size());
    cmp("sfp", m_sfp, sfp);
    $display("gating test done");
    conclude;
  end
  initial
  begin
    repeat (2000) @(posedge clk);
    num_errors++;
    conclude;
  end
endmodule
